// [bench/eicm_edge_src.sv]
// external edge source driving the channel's edge input pin
// assumes levels synchronous to clk_sys; the pin idles low while stopped
`timescale 1ns/1ps
module eicm_edge_src (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic run,
	input wire logic [15:0] period,
	output logic edgePin_q
);
	logic [15:0] phase_q;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			phase_q <= 16'h0000;
			edgePin_q <= 1'b0;
		end else if (!run) begin
			phase_q <= 16'h0000;
			edgePin_q <= 1'b0;
		end else begin
			phase_q <= (phase_q == period - 16'h0001) ? 16'h0000 : phase_q + 16'h0001;
			// four cycles high keeps the pin low between edges
			edgePin_q <= (phase_q < 16'h0004);
		end
	end
endmodule

// [bench/tb_eicm_channel.sv]
// self-checking bench for the edge-interval clock multiplier channel
// assumes the registered one-cycle wishbone ack of the channel
`timescale 1ns/1ps
`include "eicm_params.svh"
module tb_eicm_channel;
	import eicm_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic wbWe = 1'b0;
	logic [4:0] wbAdr = 5'h00;
	logic [1:0] wbSel = 2'b11;
	eicm_half_type wbDatI = 16'h0000;
	logic wbAck_q;
	eicm_half_type wbDatO_q;
	logic [3:0] irqReq_q;
	logic ch0Trigger_q;
	logic srcRun = 1'b0;
	logic [15:0] period = 16'h0400;
	logic edgePin;
	logic pinPrev = 1'b0;
	int miscompares = 0;
	int samplesChecked = 0;
	int cycles = 0;
	int edges = 0;
	int trigs = 0;
	logic mclk;
	logic cmclk;
	logic chClr;
	int mclkCnt = 0;
	int cmclkCnt = 0;
	int clrCnt = 0;
	int mLast = 0;
	eicm_half_type mGap = 16'h0000;
	eicm_half_type expQ[$];
	string nameQ[$];

	always #20 clk_sys = ~clk_sys;

	eicm_edge_src src (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.run(srcRun),
		.period(period),
		.edgePin_q(edgePin)
	);

	eicm_channel dut (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.ce(1'b1),
		.edgeInputPin(edgePin),
		.wbCyc(wbCyc),
		.wbStb(wbStb),
		.wbWe(wbWe),
		.wbAdr(wbAdr),
		.wbSel(wbSel),
		.wbDatI(wbDatI),
		.wbAck_q(wbAck_q),
		.wbDatO_q(wbDatO_q),
		.irqReq_q(irqReq_q),
		.ch0Trigger_q(ch0Trigger_q),
		.multipliedClock_q(mclk),
		.correctedMultipliedClock_q(cmclk),
		.ch12Clear_q(chClr)
	);

	task automatic reportAndStop();
		$display("comparisons %0d mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic cmpHalf(input string what, input eicm_half_type exp, input eicm_half_type got);
		samplesChecked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// request held until the edge that samples ack, released after it
	task automatic wbReq(input logic we, input logic [4:0] adr, input eicm_half_type dat,
			input logic [1:0] sel);
		@(posedge clk_sys);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbDatI <= dat;
		wbSel <= sel;
		do @(posedge clk_sys); while (wbAck_q !== 1'b1);
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] adr, input eicm_half_type dat);
		wbReq(1'b1, adr, dat, 2'b11);
	endtask

	task automatic rd(input logic [4:0] adr, input eicm_half_type exp, input string what);
		expQ.push_back(exp);
		nameQ.push_back(what);
		wbReq(1'b0, adr, 16'h0000, 2'b11);
	endtask

	// read data checked where the ack shows, against the oldest note
	always @(posedge clk_sys) begin
		cycles++;
		pinPrev <= edgePin;
		if (edgePin === 1'b1 && pinPrev === 1'b0) edges++;
		if (ch0Trigger_q === 1'b1) trigs++;
		// spacing of the last two multiplied pulses
		if (mclk === 1'b1) begin
			mclkCnt++;
			mGap <= 16'(cycles - mLast);
			mLast <= cycles;
		end
		if (cmclk === 1'b1) cmclkCnt++;
		if (chClr === 1'b1) clrCnt++;
		if (wbAck_q === 1'b1 && wbWe === 1'b0 && expQ.size() > 0) begin
			cmpHalf(nameQ.pop_front(), expQ.pop_front(), wbDatO_q);
		end
		if (cycles > 70000) begin
			miscompares++;
			reportAndStop();
		end
	end

	initial begin
		void'($urandom(32'h8651));
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		wr(`EICM_A_CNTH, 16'hA5A5);
		wr(`EICM_A_CNTL, 16'h5A5A);
		repeat (20) @(posedge clk_sys);
		rd(`EICM_A_CNTH, 16'hA5A5, "cntHigh");
		rd(`EICM_A_CNTL, 16'h5A5A, "cntLow");
		wbReq(1'b1, `EICM_A_BLNK, 16'h1234, 2'b01);
		rd(`EICM_A_BLNK, 16'h0000, "blankPartialWrite");
		wr(`EICM_A_CAPH, 16'hFFFF);
		rd(`EICM_A_CAPH, 16'h0000, "captureReadOnly");
		rd(5'h1F, 16'h0000, "unmapped");
		// edges while stopped must leave the channel untouched
		srcRun <= 1'b1;
		repeat (3000) @(posedge clk_sys);
		srcRun <= 1'b0;
		repeat (20) @(posedge clk_sys);
		rd(`EICM_A_CORD, 16'h0000, "idleEdgeCount");
		wr(`EICM_A_TOH, 16'h0000);
		wr(`EICM_A_TOL, 16'h0064);
		rd(`EICM_A_TOH, 16'h0000, "timeoutHigh");
		rd(`EICM_A_TOL, 16'h0064, "timeoutLow");
		wr(`EICM_A_EVTC, 16'h0005);
		wr(`EICM_A_MCMP, 16'h0028);
		wr(`EICM_A_IER, 16'h000F);
		edges = 0;
		wr(`EICM_A_START, 16'h0001);
		for (int f = 0; f < 4; f++) begin
			period <= 16'h0400 + 16'($urandom_range(1023));
			wr(`EICM_A_CTRL, 16'(f * 2));
			srcRun <= 1'b1;
			repeat (3 * int'(period) + 40) @(posedge clk_sys);
			rd(`EICM_A_CAPH, 16'h0000, "captureHigh");
			rd(`EICM_A_CAPL, period, "captureLow");
			rd(`EICM_A_RBUF, period >> (5 + f), "reloadBuffer");
			srcRun <= 1'b0;
			repeat (20) @(posedge clk_sys);
			// no edges now: two reloads in a row give the clean period
			repeat (128) @(posedge clk_sys);
			cmpHalf("multClockGap", period >> (5 + f), mGap);
		end
		repeat (200) @(posedge clk_sys);
		rd(`EICM_A_CORD, 16'(edges), "edgeCount");
		cmpHalf("channelZeroTrigger", 16'h0001, 16'(trigs));
		cmpHalf("irqSet", 16'h000F, {12'h000, irqReq_q});
		// stopping freezes the counters so pulse tallies can be matched
		wr(`EICM_A_START, 16'h0000);
		repeat (2) @(posedge clk_sys);
		rd(`EICM_A_MCNT, 16'(mclkCnt), "multClockCount");
		rd(`EICM_A_CORF, 16'(cmclkCnt), "corrClockCount");
		// a zero write without a prior read leaves the flags set
		wr(`EICM_A_STAT, 16'h0000);
		rd(`EICM_A_STAT, 16'h000F, "flagsHeld");
		wr(`EICM_A_STAT, 16'h0000);
		rd(`EICM_A_STAT, 16'h0000, "flagsCleared");
		repeat (3) @(posedge clk_sys);
		cmpHalf("irqCleared", 16'h0000, {12'h000, irqReq_q});
		// threshold equal to the frozen output counter clears at once
		wr(`EICM_A_CTHR, 16'(cmclkCnt));
		wr(`EICM_A_CTRL, 16'h0010);
		wr(`EICM_A_START, 16'h0001);
		wr(`EICM_A_START, 16'h0000);
		repeat (2) @(posedge clk_sys);
		cmpHalf("thresholdClear", 16'h0001, 16'(clrCnt));
		rd(`EICM_A_CORD, 16'h0000, "corrCleared");
		// blanking longer than one period swallows every other edge
		period <= 16'h0400;
		wr(`EICM_A_BLNK, 16'h0600);
		wr(`EICM_A_CTRL, 16'h0001);
		wr(`EICM_A_IER, 16'h0010);
		wr(`EICM_A_START, 16'h0001);
		srcRun <= 1'b1;
		repeat (5 * 1024 + 40) @(posedge clk_sys);
		srcRun <= 1'b0;
		rd(`EICM_A_CAPH, 16'h0000, "blankCapHigh");
		rd(`EICM_A_CAPL, 16'h0800, "blankCapLow");
		// with timing select the match waits for the next edge
		wr(`EICM_A_MCMP, 16'(mclkCnt + 4));
		repeat (800) @(posedge clk_sys);
		rd(`EICM_A_STAT, 16'h0003, "matchWaitsForEdge");
		srcRun <= 1'b1;
		repeat (10) @(posedge clk_sys);
		srcRun <= 1'b0;
		repeat (10) @(posedge clk_sys);
		rd(`EICM_A_STAT, 16'h000B, "matchAtEdge");
		repeat (5) @(posedge clk_sys);
		reportAndStop();
	end
endmodule

// [logic/eicm_channel.sv]
// edge-interval measurement and clock multiplier channel, wishbone slave
// assumes a classic 16-bit wishbone master and synchronous edge pin
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "eicm_params.svh"
// Behaviour
// RULE1: start bit runs whole channel, else frozen
// RULE2: capture and timeout are 32-bit, no mode
// RULE3: edge captures counter and restarts it at one
// RULE4: capture feeds reload path, optional capture irq
// RULE5: counter equal timeout flags compare, optional irq
// RULE6: edge pin synchronised into internal edge pulse
// RULE7: noise cancel blanks edges until blanking match
// RULE8: edge events counted, match triggers channel zero
// RULE9: interval divided by factor loads reload pair
// RULE10: down-counter at one reloads, emits clock pulse
// RULE11: multiplied clock counter compares, optional irq
// RULE12: timing select: irq at match or next edge
// RULE13: edge loads count times factor, count increments
// RULE14: target counts multiplied clock, reloads on edge
// RULE15: halt select stops target at edge count
// RULE16: output counter chases target, pulse per step
// RULE17: output counter holds while target reloads
// RULE18: corrected clock drives channels one to five
// RULE19: threshold match clears correction and channels 1,2
// RULE20: correction counters and threshold are 16 bits
// RULE21: 32-bit write: upper buffered, commit on lower
// RULE22: 32-bit read: upper read latches lower half
// RULE23: flag clears by zero write after read
// RULE24: all counting on peripheral clock, one-cycle strobes
module eicm_channel (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	input wire logic edgeInputPin,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [4:0] wbAdr,
	input wire logic [1:0] wbSel,
	input wire eicm_pkg::eicm_half_type wbDatI,
	output logic wbAck_q,
	output eicm_pkg::eicm_half_type wbDatO_q,
	output logic [3:0] irqReq_q,
	output logic ch0Trigger_q,
	output logic multipliedClock_q,
	output logic correctedMultipliedClock_q,
	output logic ch12Clear_q
);
	import eicm_pkg::*;
	logic start_q;
	logic [4:0] ctrl_q, ier_q;
	logic run, take, rd, wr, syncEdgePulse;
	logic stRd, stWr, stallHit, evtHit, mclkP, mHit, pend_q, corrClr, corrP, halt;
	logic [3:0] flagSet, flags;
	eicm_half_type wrBuf_q, rdLatch_q, rdData, quot, mul;
	eicm_word_type cnt_q, cap_q, tout_q;
	eicm_half_type blankCmp_q, evt_q, evtCmp_q, rbuf_q, down_q;
	eicm_half_type mcnt_q, mcmp_q, corD_q, corE_q, corF_q, cthr_q;
	eicm_factor_type fac;

	assign run = start_q; // RULE1
	assign fac = eicm_factor_type'(ctrl_q[`EICM_B_FAC +: 2]);
	assign take = ce & wbCyc & wbStb & ~wbAck_q;
	assign rd = take & ~wbWe;
	// partial writes are dropped: every register is a full half-word
	assign wr = take & wbWe & (&wbSel);
	assign stRd = rd & (wbAdr == `EICM_A_STAT);
	assign stWr = wr & (wbAdr == `EICM_A_STAT);

	eicm_edge_front front (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.ce(ce),
		.run(run),
		.pin(edgeInputPin),
		.noise_cancel_enable(ctrl_q[`EICM_B_NCE]),
		.blankCmp(blankCmp_q),
		.edgeOut_q(syncEdgePulse)
	);

	for (genvar i = 0; i < 4; i++) begin : g_flag
		eicm_flag flag (
			.clk_sys(clk_sys),
			.nrst(nrst),
			.ce(ce),
			.setEv(flagSet[i]),
			.rdSeen(stRd),
			.wrSeen(stWr),
			.wrBit(wbDatI[i]),
			.flag_q(flags[i])
		);
	end

	// bus handshake and read path
	always_comb begin
		rdData = `EICM_RST16;
		unique case (wbAdr)
			`EICM_A_START: rdData = {15'h0000, start_q};
			`EICM_A_CTRL: rdData = {11'h000, ctrl_q};
			`EICM_A_IER: rdData = {11'h000, ier_q};
			`EICM_A_STAT: rdData = {12'h000, flags};
			`EICM_A_CNTH: rdData = cnt_q[31:16]; // RULE22
			`EICM_A_CAPH: rdData = cap_q[31:16];
			`EICM_A_TOH: rdData = tout_q[31:16];
			`EICM_A_CNTL, `EICM_A_CAPL, `EICM_A_TOL: rdData = rdLatch_q; // RULE22
			`EICM_A_BLNK: rdData = blankCmp_q;
			`EICM_A_EVT: rdData = evt_q;
			`EICM_A_EVTC: rdData = evtCmp_q;
			`EICM_A_RBUF: rdData = rbuf_q;
			`EICM_A_DOWN: rdData = down_q;
			`EICM_A_MCNT: rdData = mcnt_q;
			`EICM_A_MCMP: rdData = mcmp_q;
			`EICM_A_CORD: rdData = corD_q;
			`EICM_A_CORE: rdData = corE_q;
			`EICM_A_CORF: rdData = corF_q;
			`EICM_A_CTHR: rdData = cthr_q;
			default: rdData = `EICM_RST16;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wbAck_q <= 1'b0;
			wbDatO_q <= `EICM_RST16;
		end else if (ce) begin
			wbAck_q <= take;
			if (rd)
				wbDatO_q <= rdData;
		end
	end

	// one shared half-word latch serves all 32-bit registers, one shared buffer the counter and timeout
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdLatch_q <= `EICM_RST16;
			wrBuf_q <= `EICM_RST16;
		end else if (ce) begin
			if (rd && wbAdr == `EICM_A_CNTH)
				rdLatch_q <= cnt_q[15:0]; // RULE22
			else if (rd && wbAdr == `EICM_A_CAPH)
				rdLatch_q <= cap_q[15:0];
			else if (rd && wbAdr == `EICM_A_TOH)
				rdLatch_q <= tout_q[15:0];
			if (wr && (wbAdr == `EICM_A_CNTH || wbAdr == `EICM_A_TOH))
				wrBuf_q <= wbDatI; // RULE21
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			start_q <= 1'b0;
			ctrl_q <= 5'h00;
			ier_q <= 5'h00;
			tout_q <= `EICM_RST32;
			blankCmp_q <= `EICM_RST16;
			evtCmp_q <= `EICM_RST16;
			mcmp_q <= `EICM_RST16;
			cthr_q <= `EICM_RST16;
		end else if (wr) begin
			unique case (wbAdr)
				`EICM_A_START: start_q <= wbDatI[`EICM_B_RUN];
				`EICM_A_CTRL: ctrl_q <= wbDatI[4:0];
				`EICM_A_IER: ier_q <= wbDatI[4:0];
				`EICM_A_TOL: tout_q <= {wrBuf_q, wbDatI}; // RULE21
				`EICM_A_BLNK: blankCmp_q <= wbDatI;
				`EICM_A_EVTC: evtCmp_q <= wbDatI;
				`EICM_A_MCMP: mcmp_q <= wbDatI;
				`EICM_A_CTHR: cthr_q <= wbDatI; // RULE20
				default: ;
			endcase
		end
	end

	// interval counter, capture and stall timeout
	assign stallHit = run & (cnt_q == tout_q); // RULE5
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= `EICM_RST32;
			cap_q <= `EICM_RST32;
		end else if (ce) begin
			// a bus write beats the count so the 32-bit value lands whole
			if (wr && wbAdr == `EICM_A_CNTL)
				cnt_q <= {wrBuf_q, wbDatI}; // RULE21
			else if (run && syncEdgePulse)
				cnt_q <= `EICM_CNT_RESTART; // RULE3
			else if (run)
				cnt_q <= cnt_q + 32'h00000001; // RULE24
			if (run && syncEdgePulse)
				cap_q <= cnt_q; // RULE2 RULE3
		end
	end

	// edge event counter
	assign evtHit = run & syncEdgePulse & (evt_q + 16'h0001 == evtCmp_q); // RULE8
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			evt_q <= `EICM_RST16;
			ch0Trigger_q <= 1'b0;
		end else if (ce) begin
			if (run && syncEdgePulse)
				evt_q <= evt_q + 16'h0001; // RULE8
			ch0Trigger_q <= evtHit; // RULE8
		end
	end

	// reload down-counter makes the multiplied clock
	assign quot = 16'(cnt_q >> (`EICM_FAC_SHIFT + 32'(fac))); // RULE9
	assign mclkP = run & ~syncEdgePulse & (down_q == `EICM_DOWN_ONE); // RULE10
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rbuf_q <= `EICM_RST16;
			down_q <= `EICM_RST16;
			multipliedClock_q <= 1'b0;
		end else if (ce) begin
			multipliedClock_q <= mclkP; // RULE10 RULE24
			if (run && syncEdgePulse) begin
				rbuf_q <= quot; // RULE4 RULE9
				down_q <= quot; // RULE9
			end else if (mclkP)
				down_q <= rbuf_q; // RULE10
			else if (run && down_q != `EICM_RST16)
				down_q <= down_q - 16'h0001; // RULE24
		end
	end

	// multiplied clock counter and compare
	assign mHit = mclkP & (mcnt_q + 16'h0001 == mcmp_q); // RULE11
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mcnt_q <= `EICM_RST16;
			pend_q <= 1'b0;
		end else if (ce) begin
			if (mclkP)
				mcnt_q <= mcnt_q + 16'h0001; // RULE11
			if (mHit && ier_q[`EICM_B_TSEL])
				pend_q <= 1'b1; // RULE12
			else if (run && syncEdgePulse)
				pend_q <= 1'b0;
		end
	end

	// correction counters
	assign mul = 16'(corD_q << (`EICM_FAC_SHIFT + 32'(fac))); // RULE13
	assign corrClr = run & ctrl_q[`EICM_B_CLREN] & (corF_q == cthr_q); // RULE19
	assign halt = ctrl_q[`EICM_B_HALT] & (corE_q == corD_q); // RULE15
	assign corrP = run & ~corrClr & ~syncEdgePulse & (corF_q < corE_q); // RULE16 RULE17
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			corD_q <= `EICM_RST16;
			corE_q <= `EICM_RST16;
			corF_q <= `EICM_RST16;
		end else if (ce && run) begin
			// the clear takes priority over an edge in the same cycle
			if (corrClr) begin
				corD_q <= `EICM_RST16; // RULE19
				corE_q <= `EICM_RST16;
				corF_q <= `EICM_RST16;
			end else if (syncEdgePulse) begin
				corE_q <= mul; // RULE13 RULE14
				corD_q <= corD_q + 16'h0001; // RULE13
			end else begin
				if (mclkP && !halt)
					corE_q <= corE_q + 16'h0001; // RULE14 RULE15
				if (corrP)
					corF_q <= corF_q + 16'h0001; // RULE16
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			correctedMultipliedClock_q <= 1'b0;
			ch12Clear_q <= 1'b0;
		end else if (ce) begin
			correctedMultipliedClock_q <= corrP; // RULE16 RULE18
			ch12Clear_q <= corrClr; // RULE19
		end
	end

	// status flags and interrupt requests
	assign flagSet[0] = run & syncEdgePulse; // RULE4
	assign flagSet[1] = stallHit; // RULE5
	assign flagSet[2] = evtHit; // RULE8
	assign flagSet[3] = ier_q[`EICM_B_TSEL] ? (pend_q & run & syncEdgePulse) : mHit; // RULE12
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			irqReq_q <= 4'h0;
		else if (ce)
			irqReq_q <= flags & ier_q[3:0]; // RULE4 RULE5 RULE11
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	capture_restart_a: assert property ( // RULE3
		ce && run && syncEdgePulse && !(wr && wbAdr == `EICM_A_CNTL)
		|=> cnt_q == `EICM_CNT_RESTART && cap_q == $past(cnt_q))
		else $error("capture or restart wrong");
	start_gate_a: assert property ( // RULE1
		!run && !(wr && wbAdr == `EICM_A_CNTL) |=> $stable(cnt_q) && !multipliedClock_q)
		else $error("channel moved while stopped");
	stall_flag_a: assert property ( // RULE5
		ce && run && cnt_q == tout_q |=> flags[1]) else $error("stall flag not set");
	divide_load_a: assert property ( // RULE9
		ce && run && syncEdgePulse |=> rbuf_q == $past(quot) && down_q == $past(quot))
		else $error("reload pair not loaded");
	reload_pulse_a: assert property ( // RULE10
		ce && mclkP |=> multipliedClock_q && down_q == $past(rbuf_q))
		else $error("reload or pulse missing");
	event_trig_a: assert property ( // RULE8
		ce && evtHit |=> ch0Trigger_q ##1 !ch0Trigger_q || !ce)
		else $error("event trigger wrong");
	corr_hold_a: assert property ( // RULE17
		ce && run && syncEdgePulse && !corrClr |=> !correctedMultipliedClock_q && $stable(corF_q))
		else $error("output counter moved on reload");
	corr_step_a: assert property ( // RULE16
		ce && corrP |=> correctedMultipliedClock_q && corF_q == $past(corF_q) + 16'h0001)
		else $error("output counter did not step");
	ack_single_a: assert property ( // RULE24
		wbAck_q |=> !wbAck_q) else $error("ack held too long");
	cap_cover: cover property (ce && run && syncEdgePulse ##1 flags[0]);
	corr_cover: cover property (correctedMultipliedClock_q ##1 correctedMultipliedClock_q);
	mcmp_cover: cover property (ier_q[`EICM_B_TSEL] && pend_q ##[1:200] flags[3]);
endmodule

// [logic/eicm_edge_front.sv]
// edge input synchroniser with optional blanking
// assumes the pin is synchronous to clk_sys; rising edges count
`timescale 1ns/1ps
`include "eicm_params.svh"
module eicm_edge_front (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	input wire logic run,
	input wire logic pin,
	input wire logic noise_cancel_enable,
	input wire eicm_pkg::eicm_half_type blankCmp,
	output logic edgeOut_q
);
	import eicm_pkg::*;
	logic s1_q, s2_q, prev_q, blank_q, rise, accept;
	eicm_half_type bcnt_q;
	assign rise = s2_q & ~prev_q;
	assign accept = rise & run & ~blank_q; // RULE7
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			prev_q <= 1'b0;
			edgeOut_q <= 1'b0;
		end else if (ce) begin
			s1_q <= pin; // RULE6
			s2_q <= s1_q;
			prev_q <= s2_q;
			edgeOut_q <= accept; // RULE6
		end
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			blank_q <= 1'b0;
			bcnt_q <= `EICM_RST16;
		end else if (ce && run) begin
			// a stopped channel freezes its blanking window too
			if (accept & noise_cancel_enable) begin
				blank_q <= 1'b1; // RULE7
				bcnt_q <= `EICM_RST16;
			end else if (blank_q) begin
				if (bcnt_q == blankCmp)
					blank_q <= 1'b0;
				else
					bcnt_q <= bcnt_q + 16'h0001;
			end
		end
	end
	blank_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE7
		ce && blank_q |=> !edgeOut_q) else $error("edge passed during blanking");
	edge_sync_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE6
		ce && run && s2_q && !prev_q && !blank_q |=> edgeOut_q)
		else $error("synchronised edge not passed on");
endmodule

// [logic/eicm_flag.sv]
// one sticky interrupt status flag
// assumes the owner decodes status reads and writes
`timescale 1ns/1ps
module eicm_flag (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	input wire logic setEv,
	input wire logic rdSeen,
	input wire logic wrSeen,
	input wire logic wrBit,
	output logic flag_q
);
	logic armed_q;
	logic clr;
	assign clr = wrSeen & ~wrBit & armed_q; // RULE23
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			flag_q <= 1'b0;
			armed_q <= 1'b0;
		end else if (ce) begin
			// set wins over a clear in the same cycle
			flag_q <= setEv | (flag_q & ~clr); // RULE23
			if (clr)
				armed_q <= 1'b0;
			else if (rdSeen & flag_q)
				armed_q <= 1'b1;
		end
	end
endmodule

// [logic/eicm_params.svh]
// constants of the edge-interval clock multiplier channel
// assumes a 16-bit wishbone data path addressed in 16-bit words
`ifndef EICM_PARAMS_SVH
`define EICM_PARAMS_SVH
`define EICM_A_START 5'h00
`define EICM_A_CTRL 5'h01
`define EICM_A_IER 5'h02
`define EICM_A_STAT 5'h03
`define EICM_A_CNTH 5'h04
`define EICM_A_CNTL 5'h05
`define EICM_A_CAPH 5'h06
`define EICM_A_CAPL 5'h07
`define EICM_A_TOH 5'h08
`define EICM_A_TOL 5'h09
`define EICM_A_BLNK 5'h0A
`define EICM_A_EVT 5'h0B
`define EICM_A_EVTC 5'h0C
`define EICM_A_RBUF 5'h0D
`define EICM_A_DOWN 5'h0E
`define EICM_A_MCNT 5'h0F
`define EICM_A_MCMP 5'h10
`define EICM_A_CORD 5'h11
`define EICM_A_CORE 5'h12
`define EICM_A_CORF 5'h13
`define EICM_A_CTHR 5'h14
`define EICM_B_RUN 0
`define EICM_B_NCE 0
`define EICM_B_FAC 1
`define EICM_B_HALT 3
`define EICM_B_CLREN 4
`define EICM_B_TSEL 4
`define EICM_FAC_SHIFT 5
`define EICM_CNT_RESTART 32'h00000001
`define EICM_DOWN_ONE 16'h0001
`define EICM_RST32 32'h00000000
`define EICM_RST16 16'h0000
`endif

// [logic/eicm_pkg.sv]
// types of the edge-interval clock multiplier channel
// assumes nothing beyond the params header
package eicm_pkg;
	typedef logic [15:0] eicm_half_type;
	typedef logic [31:0] eicm_word_type;
	typedef enum logic [1:0] {
		EICM_X32 = 2'b00,
		EICM_X64 = 2'b01,
		EICM_X128 = 2'b10,
		EICM_X256 = 2'b11
	} eicm_factor_type;
endpackage
